// *** sbc_consts.svh ***
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH
// Summary of operation
// - Reset output low while in reset, one clock behind the mode
// - Enabled pending source holds interrupt low
// - Stop mode wake pulses interrupt about 10us
// - Serial port works only with select low
// - Watchdog fault output low on service failure
// - Window or timeout watchdog, software selected
// - Watchdog failure drives fault and reset low
// - Battery below 3.0V latches supply loss
// - Below 6.0V warns, Normal/Standby only
// - Main over-temperature flags both registers
// - Aux supply below 4.0V sets flag
// - Switch over-temperature sets the shared switch/aux flag
// - Switch follows its on control bit
// - Cyclic switch in Sleep/Stop, static otherwise
// - Receive output reports bus state
// - Bus interface mode set by software
// - Wake inputs readable and wake the chip
// - Software selects among four modes
// - Transmit low means dominant, dominant reads low
// - Reset held for 15 ms
// - Supply low (not in Sleep) or watchdog error enters reset
// - Sample on falling, shift out after rising

// ----------------------------------------
// Register offsets and serial indexes
// ----------------------------------------
`define ADR_MODE 8'h00
`define ADR_IRQ 8'h04
`define ADR_IO 8'h08
`define ADR_WDC 8'h0C
`define ADR_WDS 8'h10
`define IDX_MODE 3'h0
`define IDX_IRQ 3'h1
`define IDX_IO 3'h2
`define IDX_WDC 3'h3
`define IDX_WDS 3'h4
`define IDX_NONE 3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MCR_LOSS 2
`define MCR_OT 3
`define IRQ_BAT 0
`define IRQ_OT 1
`define IRQ_HSAUX 2
`define IRQ_WAKE 3
`define SPI_WR 7
`define SPI_FRAME 5'h10
`define SPI_CMD 5'h08
`define SYNC_RST 15'h2800

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_KHZ 25000
`define CLK_PERIOD_NS 40
`define RESET_HOLD_MS 15
`define RESET_HOLD_CYC (`RESET_HOLD_MS * `CLK_KHZ)
`define WAKE_PULSE_NS 10000
`define WAKE_PULSE_CYC (`WAKE_PULSE_NS / `CLK_PERIOD_NS)
`define WD_BASE_MS 8
`define WD_BASE_CYC (`WD_BASE_MS * `CLK_KHZ)
`define HS_PERIOD_MS 100
`define HS_PERIOD_CYC (`HS_PERIOD_MS * `CLK_KHZ)
`define HS_ON_MS 1
`define HS_ON_CYC (`HS_ON_MS * `CLK_KHZ)
`endif

// *** sbc_pkg.sv ***
package sbc_pkg;
	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_NORMAL = 3'h1,
		ST_STANDBY = 3'h2,
		ST_STOP = 3'h3,
		ST_SLEEP = 3'h4
	} op_mode_e;
	typedef enum logic [1:0] {
		REQ_NORMAL = 2'h0,
		REQ_STANDBY = 2'h1,
		REQ_STOP = 2'h2,
		REQ_SLEEP = 2'h3
	} req_mode_e;
	typedef logic [7:0] byte_t;
endpackage

// *** supervisor_status_and_irq_pins.sv ***
`timescale 1ns/100ps
`include "sbc_consts.svh"
module supervisor_status_and_irq_pins #(
	parameter int unsigned RESET_HOLD_CYC = `RESET_HOLD_CYC,
	parameter int unsigned WD_BASE_CYC = `WD_BASE_CYC,
	parameter int unsigned HS_PERIOD_CYC = `HS_PERIOD_CYC,
	parameter int unsigned HS_ON_CYC = `HS_ON_CYC
)(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial port
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	// Bus transceiver
	input wire logic txd_i,
	input wire logic can_bus_dom_i,
	output logic rxd_o,
	output logic can_drive_dom_o,
	output sbc_pkg::req_mode_e can_mode_o,
	// Supply, temperature and wake sense
	input wire logic bat_below_3v_i,
	input wire logic bat_below_6v_i,
	input wire logic vdd_low_i,
	input wire logic main_overtemp_i,
	input wire logic aux_supply_sense_low_i,
	input wire logic hiside_overtemp_i,
	input wire logic [3:0] wake_inputs_i,
	// Supervisory pins
	output logic sys_reset_out_low_o,
	output logic irq_n_o,
	output logic watchdog_fault_low_o,
	output logic hiside_switch_out_o,
	output logic aux_pass_drive_o
);
	import sbc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [14:0] s1_reg, s1_next, s2_reg, s2_next, sp_reg, sp_next;
	op_mode_e mode_reg, mode_next;
	req_mode_e req_reg, req_next, can_mode_reg, can_mode_next;
	logic [18:0] rst_cnt_reg, rst_cnt_next;
	logic [23:0] wd_cnt_reg, wd_cnt_next;
	logic wd_win_reg, wd_win_next, hs_cyc_reg, hs_cyc_next;
	logic [1:0] wd_sel_reg, wd_sel_next;
	logic hs_on_reg, hs_on_next, loss_reg, loss_next, ot_reg, ot_next;
	logic [3:0] irq_en_reg, irq_en_next, pend_reg, pend_next;
	logic wdf_reg, wdf_next;
	logic [7:0] pulse_reg, pulse_next;
	logic [21:0] hs_tmr_reg, hs_tmr_next;
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic [4:0] bits_reg, bits_next;
	logic [7:0] sin_reg, sin_next, sout_reg, sout_next;
	logic miso_reg, miso_next, sys_reset_out_low_reg, sys_reset_out_low_next, irqn_reg, irqn_next;
	logic wdfn_reg, wdfn_next, hs_reg, hs_next, aux_reg, aux_next;
	logic rxd_reg, rxd_next, dom_reg, dom_next;

	// Synchronised views
	logic sclk_s, cs_n_s, mosi_s, txd_s, dom_s, bat3_s, bat6_s;
	logic vdd_s, mot_s, aux_s, hiside_overtemp_flag_s;
	logic [3:0] wake_s;
	assign {sclk_s, cs_n_s, mosi_s, txd_s, dom_s, bat3_s, bat6_s,
		vdd_s, mot_s, aux_s, hiside_overtemp_flag_s, wake_s} = s2_reg;

	// Combinational helpers
	logic wb_hit, wr_go, sclk_fall, sclk_rise, run_mode, wake_ev;
	logic wd_expire, wd_early;
	logic [2:0] wb_idx, wr_idx;
	logic [7:0] wr_dat;
	logic [7:0] sin_full;
	logic [23:0] wd_limit;

	// Command byte bookkeeping for serial writes
	logic [2:0] spi_cmd_idx;
	logic [7:0] spi_cmd_reg, spi_cmd_next;

	// ----------------------------------------
	// Decode and readback
	// ----------------------------------------
	function automatic logic [2:0] adr_to_idx(input logic [7:0] adr);
		if (adr == `ADR_MODE) begin
			return `IDX_MODE;
		end else if (adr == `ADR_IRQ) begin
			return `IDX_IRQ;
		end else if (adr == `ADR_IO) begin
			return `IDX_IO;
		end else if (adr == `ADR_WDC) begin
			return `IDX_WDC;
		end else if (adr == `ADR_WDS) begin
			return `IDX_WDS;
		end else begin
			return `IDX_NONE;
		end
	endfunction

	function automatic byte_t rd_fn(input logic [2:0] idx);
		byte_t v;
		v = 8'h00;
		case (idx)
			`IDX_MODE: v = {1'b0, mode_reg, ot_reg, loss_reg, req_reg};
			`IDX_IRQ: v = {pend_reg, irq_en_reg};
			// Live levels; warning only counts in running modes
			`IDX_IO: v = {wake_s, bat6_s & run_mode, aux_s, hiside_overtemp_flag_s, hs_on_reg};
			`IDX_WDC: v = {2'h0, can_mode_reg, hs_cyc_reg, wd_sel_reg, wd_win_reg};
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		s1_next = {spi_sclk_i, spi_cs_n_i, spi_mosi_i, txd_i, can_bus_dom_i,
			bat_below_3v_i, bat_below_6v_i, vdd_low_i, main_overtemp_i,
			aux_supply_sense_low_i, hiside_overtemp_i, wake_inputs_i};
		s2_next = s1_reg;
		sp_next = s2_reg;
		mode_next = mode_reg;
		req_next = req_reg;
		can_mode_next = can_mode_reg;
		rst_cnt_next = rst_cnt_reg;
		wd_cnt_next = wd_cnt_reg;
		wd_win_next = wd_win_reg;
		wd_sel_next = wd_sel_reg;
		hs_cyc_next = hs_cyc_reg;
		hs_on_next = hs_on_reg;
		loss_next = loss_reg;
		ot_next = ot_reg;
		irq_en_next = irq_en_reg;
		pend_next = pend_reg;
		wdf_next = wdf_reg;
		pulse_next = (pulse_reg != 8'h00) ? pulse_reg - 8'h01 : 8'h00;
		hs_tmr_next = hs_tmr_reg;
		bits_next = bits_reg;
		sin_next = sin_reg;
		sout_next = sout_reg;
		miso_next = miso_reg;
		run_mode = (mode_reg == ST_NORMAL) || (mode_reg == ST_STANDBY);

		// Wishbone: one wait state, unmapped reads zero
		wb_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
		wb_idx = adr_to_idx(wb_adr_i);
		ack_next = wb_hit;
		dat_next = wb_hit ? {24'h000000, rd_fn(wb_idx)} : dat_reg;

		// Serial port on sampled clock edges
		sclk_fall = sp_reg[14] & ~sclk_s;
		sclk_rise = ~sp_reg[14] & sclk_s;
		sin_full = {sin_reg[6:0], mosi_s};
		wr_go = 1'b0;
		wr_idx = `IDX_NONE;
		wr_dat = 8'h00;
		if (cs_n_s) begin
			bits_next = 5'h00;
			miso_next = 1'b0;
		end else begin
			if (sclk_fall && bits_reg != `SPI_FRAME) begin
				sin_next = sin_full;
				bits_next = bits_reg + 5'h01;
				if (bits_reg == `SPI_CMD - 5'h01) begin
					sout_next = rd_fn(sin_full[6:4]);
				end
			end
			if (sclk_rise && bits_reg >= `SPI_CMD && bits_reg != `SPI_FRAME) begin
				miso_next = sout_reg[7];
				sout_next = {sout_reg[6:0], 1'b0};
			end
		end

		// Wishbone write wins a collision; serial write is dropped
		if (wb_hit && wb_we_i && wb_sel_i[0] && wb_idx != `IDX_NONE) begin
			wr_go = 1'b1;
			wr_idx = wb_idx;
			wr_dat = wb_dat_i[7:0];
		end else if (cs_n_s == 1'b0 && sclk_fall && bits_reg == `SPI_FRAME - 5'h01
				&& spi_cmd_reg[`SPI_WR]) begin
			// Write lands on the last data bit
			wr_go = 1'b1;
			wr_idx = spi_cmd_idx;
			wr_dat = sin_full;
		end

		// Watchdog limits
		wd_limit = 24'(WD_BASE_CYC << wd_sel_reg);
		wd_early = wd_win_reg && (wd_cnt_reg < (wd_limit >> 1));
		wd_expire = 1'b0;

		// Register writes; flags clear by writing one
		if (wr_go) begin
			case (wr_idx)
				`IDX_MODE: begin
					req_next = req_mode_e'(wr_dat[1:0]);
					if (run_mode) begin
						case (req_mode_e'(wr_dat[1:0]))
							REQ_NORMAL: mode_next = ST_NORMAL;
							REQ_STANDBY: mode_next = ST_STANDBY;
							REQ_STOP: mode_next = ST_STOP;
							default: mode_next = ST_SLEEP;
						endcase
					end
					loss_next = loss_reg & ~wr_dat[`MCR_LOSS];
					ot_next = ot_reg & ~wr_dat[`MCR_OT];
				end
				`IDX_IRQ: begin
					irq_en_next = wr_dat[3:0];
					pend_next = pend_reg & ~wr_dat[7:4];
				end
				`IDX_IO: hs_on_next = wr_dat[0];
				`IDX_WDC: begin
					wd_win_next = wr_dat[0];
					wd_sel_next = wr_dat[2:1];
					hs_cyc_next = wr_dat[3];
					can_mode_next = req_mode_e'(wr_dat[5:4]);
				end
				`IDX_WDS: begin
					if (run_mode && wd_early) begin
						wd_expire = 1'b1;
					end
					wd_cnt_next = 24'h000000;
				end
				default: begin
				end
			endcase
		end

		// Sticky flags; a new event beats a same-cycle clear
		if (bat3_s) begin
			loss_next = 1'b1;
		end
		if (mot_s & ~sp_reg[6]) begin
			ot_next = 1'b1;
			pend_next[`IRQ_OT] = 1'b1;
		end
		if (run_mode && bat6_s && !sp_reg[8]) begin
			pend_next[`IRQ_BAT] = 1'b1;
		end
		if ((hiside_overtemp_flag_s & ~sp_reg[4]) | (aux_s & ~sp_reg[5])) begin
			pend_next[`IRQ_HSAUX] = 1'b1;
		end

		// Watchdog runs in Normal and Standby
		if (run_mode) begin
			if (!(wr_go && wr_idx == `IDX_WDS)) begin
				wd_cnt_next = wd_cnt_reg + 24'h000001;
			end
			if (wd_cnt_reg >= wd_limit - 24'h000001) begin
				wd_expire = 1'b1;
			end
		end else begin
			wd_cnt_next = 24'h000000;
		end

		// Wake from level change or bus activity
		wake_ev = (wake_s != sp_reg[3:0]) || dom_s;
		hs_tmr_next = (hs_tmr_reg >= 22'(HS_PERIOD_CYC - 1)) ? 22'h000000
			: hs_tmr_reg + 22'h000001;

		// Mode sequencing, reset causes last so they dominate
		case (mode_reg)
			ST_STOP: begin
				if (wake_ev) begin
					mode_next = ST_NORMAL;
					pulse_next = 8'(`WAKE_PULSE_CYC);
					pend_next[`IRQ_WAKE] = 1'b1;
				end
			end
			ST_SLEEP: begin
				if (wake_ev) begin
					mode_next = ST_RESET;
					rst_cnt_next = 19'h00000;
				end
			end
			ST_RESET: begin
				rst_cnt_next = rst_cnt_reg + 19'h00001;
				if (rst_cnt_reg >= 19'(RESET_HOLD_CYC - 1)) begin
					mode_next = ST_NORMAL;
					wdf_next = 1'b0;
					rst_cnt_next = 19'h00000;
				end
			end
			default: begin
			end
		endcase
		if (mode_reg != ST_RESET && mode_reg != ST_SLEEP && (vdd_s || wd_expire)) begin
			mode_next = ST_RESET;
			rst_cnt_next = 19'h00000;
			wdf_next = wd_expire;
			wd_cnt_next = 24'h000000;
		end else if (mode_reg == ST_RESET && vdd_s) begin
			rst_cnt_next = 19'h00000;
		end

		// Pin outputs from current state
		sys_reset_out_low_next = (mode_reg != ST_RESET);
		irqn_next = !(|(pend_reg & irq_en_reg)) && (pulse_reg == 8'h00);
		wdfn_next = ~wdf_reg;
		aux_next = (mode_reg == ST_NORMAL);
		if (hiside_overtemp_flag_s || mode_reg == ST_RESET) begin
			hs_next = 1'b0;
		end else if (run_mode) begin
			hs_next = hs_on_reg;
		end else begin
			hs_next = hs_cyc_reg && hs_tmr_reg < 22'(HS_ON_CYC);
		end
		dom_next = (mode_reg == ST_NORMAL) && (can_mode_reg != REQ_NORMAL) && !txd_s;
		rxd_next = ~dom_s;
	end

	assign spi_cmd_idx = spi_cmd_reg[6:4];
	always_comb begin
		spi_cmd_next = spi_cmd_reg;
		if (!cs_n_s && sclk_fall && bits_reg == `SPI_CMD - 5'h01) begin
			spi_cmd_next = sin_full;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= `SYNC_RST;
			s2_reg <= `SYNC_RST;
			sp_reg <= `SYNC_RST;
			mode_reg <= ST_RESET;
			req_reg <= REQ_NORMAL;
			can_mode_reg <= REQ_NORMAL;
			rst_cnt_reg <= 19'h00000;
			wd_cnt_reg <= 24'h000000;
			wd_win_reg <= 1'b0;
			wd_sel_reg <= 2'h0;
			hs_cyc_reg <= 1'b0;
			hs_on_reg <= 1'b0;
			loss_reg <= 1'b0;
			ot_reg <= 1'b0;
			irq_en_reg <= 4'h0;
			pend_reg <= 4'h0;
			wdf_reg <= 1'b0;
			pulse_reg <= 8'h00;
			hs_tmr_reg <= 22'h000000;
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
			bits_reg <= 5'h00;
			sin_reg <= 8'h00;
			sout_reg <= 8'h00;
			spi_cmd_reg <= 8'h00;
			miso_reg <= 1'b0;
			sys_reset_out_low_reg <= 1'b0;
			irqn_reg <= 1'b1;
			wdfn_reg <= 1'b1;
			hs_reg <= 1'b0;
			aux_reg <= 1'b0;
			rxd_reg <= 1'b1;
			dom_reg <= 1'b0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			sp_reg <= sp_next;
			mode_reg <= mode_next;
			req_reg <= req_next;
			can_mode_reg <= can_mode_next;
			rst_cnt_reg <= rst_cnt_next;
			wd_cnt_reg <= wd_cnt_next;
			wd_win_reg <= wd_win_next;
			wd_sel_reg <= wd_sel_next;
			hs_cyc_reg <= hs_cyc_next;
			hs_on_reg <= hs_on_next;
			loss_reg <= loss_next;
			ot_reg <= ot_next;
			irq_en_reg <= irq_en_next;
			pend_reg <= pend_next;
			wdf_reg <= wdf_next;
			pulse_reg <= pulse_next;
			hs_tmr_reg <= hs_tmr_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
			bits_reg <= bits_next;
			sin_reg <= sin_next;
			sout_reg <= sout_next;
			spi_cmd_reg <= spi_cmd_next;
			miso_reg <= miso_next;
			sys_reset_out_low_reg <= sys_reset_out_low_next;
			irqn_reg <= irqn_next;
			wdfn_reg <= wdfn_next;
			hs_reg <= hs_next;
			aux_reg <= aux_next;
			rxd_reg <= rxd_next;
			dom_reg <= dom_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign spi_miso_o = miso_reg;
	assign rxd_o = rxd_reg;
	assign can_drive_dom_o = dom_reg;
	assign can_mode_o = can_mode_reg;
	assign sys_reset_out_low_o = sys_reset_out_low_reg;
	assign irq_n_o = irqn_reg;
	assign watchdog_fault_low_o = wdfn_reg;
	assign hiside_switch_out_o = hs_reg;
	assign aux_pass_drive_o = aux_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_stop_wake;
		mode_reg == ST_STOP && wake_ev;
	endsequence
	sequence s_leave_reset;
		mode_reg == ST_RESET && mode_next == ST_NORMAL;
	endsequence

	chk_reset_pin: assert property (sys_reset_out_low_o == $past(mode_reg != ST_RESET))
		else $error("reset pin disagrees with mode");
	chk_irq_pending: assert property (|(pend_reg & irq_en_reg) |=> !irq_n_o)
		else $error("enabled pending source left interrupt high");
	chk_irq_idle: assert property (!(|(pend_reg & irq_en_reg)) && pulse_reg == 8'h00 |=> irq_n_o)
		else $error("interrupt low with nothing enabled pending");
	chk_wake_pulse: assert property (s_stop_wake |=> ##1 (!irq_n_o)[*8])
		else $error("stop wake pulse missing");
	chk_spi_deselect: assert property (cs_n_s |=> bits_reg == 5'h00 && !wr_go || wb_hit)
		else $error("serial port active while deselected");
	chk_wd_both_low: assert property ($fell(watchdog_fault_low_o) |-> !sys_reset_out_low_o)
		else $error("watchdog fault without reset");
	chk_reset_hold: assert property (s_leave_reset |-> rst_cnt_reg == 19'(RESET_HOLD_CYC - 1))
		else $error("reset left before hold time");
	chk_supply_loss: assert property (bat3_s |=> loss_reg)
		else $error("supply loss not latched");
	chk_can_drive: assert property (mode_reg == ST_NORMAL && can_mode_reg != REQ_NORMAL && !txd_s
		|=> can_drive_dom_o)
		else $error("dominant not driven for low transmit");
	chk_rxd_state: assert property (dom_s |=> !rxd_o)
		else $error("receive output high on dominant bus");
	chk_hs_static: assert property (run_mode && !hiside_overtemp_flag_s |=> hiside_switch_out_o == $past(hs_on_reg))
		else $error("switch does not follow control bit");
endmodule

// *** mcu_model.sv ***
`timescale 1ns/100ps
module mcu_model (
	// Clock
	input wire logic clk_i,
	// Serial and transmit pins
	input wire logic miso_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	output logic txd_o
);
	// ----------------------------------------
	// Serial master and transmit driver
	// ----------------------------------------
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
		txd_o = 1'b1;
	end
	// Eight clocks per bit: sclk 3.125 MHz, four clocks per phase
	task automatic xfer(input logic sel, input logic [15:0] f, output logic [7:0] rd);
		cs_n_o <= ~sel;
		repeat (4) @(posedge clk_i);
		for (int i = 0; i < 16; i++) begin
			mosi_o <= f[15 - i];
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b0;
			rd = {rd[6:0], miso_i};
			repeat (4) @(posedge clk_i);
		end
		cs_n_o <= 1'b1;
		// Released line must not keep showing the last bit
		mosi_o <= ~mosi_o;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic drive_txd(input logic b);
		txd_o <= b;
	endtask
endmodule

// *** supervisor_status_and_irq_pins_tb.sv ***
`timescale 1ns/100ps
`include "sbc_consts.svh"
module supervisor_status_and_irq_pins_tb;
	import sbc_pkg::*;
	localparam int unsigned HOLD = 20;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_i = 1'b0, rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic wb_ack_o, spi_sclk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o;
	logic txd_i, can_bus_dom_i = 1'b0, rxd_o, can_drive_dom_o;
	req_mode_e can_mode_o;
	logic bat_below_3v_i = 1'b0, bat_below_6v_i = 1'b0, vdd_low_i = 1'b0;
	logic main_overtemp_i = 1'b0, aux_supply_sense_low_i = 1'b0, hiside_overtemp_i = 1'b0;
	logic [3:0] wake_inputs_i = 4'h0;
	logic sys_reset_out_low_o, irq_n_o, watchdog_fault_low_o;
	logic hiside_switch_out_o, aux_pass_drive_o;
	logic [31:0] rd;
	logic [7:0] sd;
	int errors = 0, n_checks = 0, cnt;
	always #20 clk_i = ~clk_i;
	supervisor_status_and_irq_pins #(.RESET_HOLD_CYC(HOLD), .WD_BASE_CYC(40),
		.HS_PERIOD_CYC(32), .HS_ON_CYC(4)) DUT (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .spi_sclk_i, .spi_cs_n_i, .spi_mosi_i,
		.spi_miso_o, .txd_i, .can_bus_dom_i, .rxd_o, .can_drive_dom_o, .can_mode_o,
		.bat_below_3v_i, .bat_below_6v_i, .vdd_low_i, .main_overtemp_i,
		.aux_supply_sense_low_i, .hiside_overtemp_i, .wake_inputs_i,
		.sys_reset_out_low_o, .irq_n_o, .watchdog_fault_low_o,
		.hiside_switch_out_o, .aux_pass_drive_o);
	mcu_model mcu (.clk_i, .miso_i(spi_miso_o), .sclk_o(spi_sclk_i),
		.cs_n_o(spi_cs_n_i), .mosi_o(spi_mosi_i), .txd_o(txd_i));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
		int k;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= {24'h0, d};
		for (k = 0; k < 20; k++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1) break;
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (k == 20) begin
			errors++;
			tally_and_finish();
		end
		@(posedge clk_i);
	endtask
	// Bounded wait for the watchdog fault pin to fall
	task automatic wait_fault();
		for (cnt = 0; cnt < 40 && watchdog_fault_low_o !== 1'b0; cnt++) @(posedge clk_i);
		if (cnt == 40) begin
			errors++;
			tally_and_finish();
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("rst_pin", sys_reset_out_low_o, 0);
		chk("irq_idle", irq_n_o, 1);
		chk("fault_idle", watchdog_fault_low_o, 1);
		// Bus interface on from the start so the link pins can drive
		wb(1, `ADR_WDC, 8'h16);
		repeat (10) @(posedge clk_i);
		chk("rst_hold", sys_reset_out_low_o, 0);
		repeat (14) @(posedge clk_i);
		chk("rst_end", sys_reset_out_low_o, 1);
		wb(1, 8'h3C, 8'hFF);
		wb(0, 8'h3C, 8'h00);
		chk("unmapped", rd, 0);
		for (int m = 1; m >= 0; m--) begin
			wb(1, `ADR_MODE, 8'(m));
			wb(0, `ADR_MODE, 8'h00);
			chk("state", rd[6:4], m + 1);
			chk("aux_drive", aux_pass_drive_o, m == 0);
		end
		// Enabled source holds interrupt until cleared
		wb(1, `ADR_IRQ, 8'h02);
		main_overtemp_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		main_overtemp_i <= 1'b0;
		chk("irq_ot", irq_n_o, 0);
		wb(0, `ADR_MODE, 8'h00);
		chk("mode_ot", rd[3], 1);
		wb(0, `ADR_IRQ, 8'h00);
		chk("irq_ot_flag", rd[5], 1);
		chk("irq_held", irq_n_o, 0);
		wb(1, `ADR_IRQ, 8'h22);
		wb(1, `ADR_MODE, 8'h08);
		chk("irq_clr", irq_n_o, 1);
		// Masked early warning keeps interrupt high
		wb(1, `ADR_IRQ, 8'h00);
		bat_below_6v_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("irq_mask", irq_n_o, 1);
		wb(0, `ADR_IO, 8'h00);
		chk("io_6v", rd[3], 1);
		bat_below_6v_i <= 1'b0;
		bat_below_3v_i <= 1'b1;
		aux_supply_sense_low_i <= 1'b1;
		hiside_overtemp_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		bat_below_3v_i <= 1'b0;
		wb(0, `ADR_IO, 8'h00);
		chk("io_aux_ot", rd[2:1], 3);
		wb(0, `ADR_IRQ, 8'h00);
		chk("irq_hs_flag", rd[6], 1);
		aux_supply_sense_low_i <= 1'b0;
		hiside_overtemp_i <= 1'b0;
		wb(0, `ADR_MODE, 8'h00);
		chk("loss_set", rd[2], 1);
		wb(1, `ADR_MODE, 8'h04);
		wb(1, `ADR_IRQ, 8'hF0);
		wb(0, `ADR_MODE, 8'h00);
		chk("loss_clr", rd[2], 0);
		wb(1, `ADR_WDS, 8'h00);
		// Switch control, wake levels and link pins
		wb(1, `ADR_IO, 8'h01);
		chk("hs_on", hiside_switch_out_o, 1);
		wb(1, `ADR_IO, 8'h00);
		chk("hs_off", hiside_switch_out_o, 0);
		wake_inputs_i <= 4'hA;
		mcu.drive_txd(1'b0);
		can_bus_dom_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("dom_drive", can_drive_dom_o, 1);
		chk("rxd_dom", rxd_o, 0);
		mcu.drive_txd(1'b1);
		can_bus_dom_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk("rec_drive", can_drive_dom_o, 0);
		chk("rxd_rec", rxd_o, 1);
		for (int m = 0; m < 4; m++) begin
			wb(1, `ADR_WDC, 8'h06 | 8'(m << 4));
			chk("can_mode", can_mode_o, m);
		end
		// Serial write, deselected frame, then read back
		wb(1, `ADR_WDS, 8'h00);
		mcu.xfer(1'b1, 16'hA001, sd);
		chk("spi_wr", hiside_switch_out_o, 1);
		mcu.xfer(1'b0, 16'hA000, sd);
		chk("spi_desel", hiside_switch_out_o, 1);
		// Serial frames are long; service before the watchdog runs out
		wb(1, `ADR_WDS, 8'h00);
		mcu.xfer(1'b1, 16'h2000, sd);
		chk("spi_rd", sd, 8'hA1);
		wb(1, `ADR_IO, 8'h00);
		// Stop mode: cyclic switch, then wake pulse
		wb(1, `ADR_WDC, 8'h0E);
		wb(1, `ADR_MODE, 8'h02);
		cnt = 0;
		repeat (64) begin
			@(posedge clk_i);
			cnt += hiside_switch_out_o === 1'b1;
		end
		chk("hs_cyclic", cnt, 8);
		wake_inputs_i <= 4'h5;
		for (cnt = 0; cnt < 50 && irq_n_o !== 1'b0; cnt++) @(posedge clk_i);
		for (cnt = 0; cnt < 400 && irq_n_o === 1'b0; cnt++) @(posedge clk_i);
		chk("wake_pulse", cnt, 250);
		wb(0, `ADR_MODE, 8'h00);
		chk("wake_state", rd[6:4], 1);
		// Supply low and watchdog failures
		vdd_low_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("vdd_rst", sys_reset_out_low_o, 0);
		vdd_low_i <= 1'b0;
		repeat (HOLD + 8) @(posedge clk_i);
		chk("vdd_rel", sys_reset_out_low_o, 1);
		wb(1, `ADR_WDC, 8'h00);
		wb(1, `ADR_WDS, 8'h00);
		repeat (30) @(posedge clk_i);
		chk("wd_ok", watchdog_fault_low_o, 1);
		wait_fault();
		chk("wd_rst", sys_reset_out_low_o, 0);
		repeat (HOLD + 4) @(posedge clk_i);
		wb(1, `ADR_WDC, 8'h07);
		wb(1, `ADR_WDS, 8'h00);
		wait_fault();
		chk("win_rst", sys_reset_out_low_o, 0);
		tally_and_finish();
	end
endmodule
